/* sps_engine.sv */
// Four-mode serial shift engine with an APB register port
`timescale 1ns/1ps
`include "sps_defines.svh"

module sps_engine (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // Baud source from the timer block, same clock
   input  wire logic        timer_overflow,
   // Serial pins
   input  wire logic        rxd_in,
   output      logic        rxd_out,
   output      logic        rxd_oe_n,
   output      logic        txd
);

   sps_pkg::sps_state_t q;
   sps_pkg::sps_state_t next_q;

   logic tick;
   logic tx_roll;
   logic mc_end;
   logic tx_last;
   logic vote;
   logic setup;
   logic wr;
   logic wr_data;
   logic set_ti;
   logic set_ri;
   logic m0_clk;

   // Two-of-three majority
   function automatic logic sps_major(input logic a, input logic b, input logic c);
      sps_major = (a & b) | (a & c) | (b & c);
   endfunction : sps_major

   // *****************************************************
   // Next state
   // *****************************************************

   // Whole engine update
   always_comb
   begin
      next_q  = q;
      tick    = 1'b0;
      set_ti  = 1'b0;
      set_ri  = 1'b0;
      wr_data = 1'b0;
      mc_end  = (q.phase == `SPS_MC_LAST);
      next_q.phase = mc_end ? 4'h0 : q.phase + 4'h1;
      // Sixteen-times bit rate tick
      if (q.mode == `SPS_MODE2)
      begin
         if (q.pre_div == (q.baud_double_bit ? `SPS_M2_FAST : `SPS_M2_SLOW))
         begin
            next_q.pre_div = 2'h0;
            tick           = 1'b1;
         end
         else
         begin
            next_q.pre_div = q.pre_div + 2'h1;
         end
      end
      else if (timer_overflow)
      begin
         next_q.half = ~q.half;
         tick        = q.baud_double_bit | q.half;
      end
      tx_roll       = tick && (q.tx_div == `SPS_ROLL);
      next_q.tx_div = tick ? q.tx_div + 4'h1 : q.tx_div;
      // Pin synchroniser and edge history
      next_q.sync1 = rxd_in;
      next_q.sync2 = q.sync1;
      if (tick)
      begin
         next_q.rx_prev = q.sync2;
      end
      // APB decode, zero wait states
      setup          = psel & ~penable;
      wr             = psel & penable & q.pready & pwrite;
      next_q.pready  = setup;
      next_q.pslverr = 1'b0;
      next_q.prdata  = 32'h0000_0000;
      if (setup)
      begin
         case (paddr)
            `SPS_CTRL_ADDR: next_q.prdata = {26'h0, q.baud_double_bit, q.tb8, q.sm2, q.ren, q.mode};
            `SPS_DATA_ADDR: next_q.prdata = {24'h0, q.serial_buffer};
            `SPS_STAT_ADDR: next_q.prdata = {27'h0, q.rx_state != sps_pkg::SPS_RX_IDLE,
                                             q.tx_state inside {sps_pkg::SPS_TX_M0,
                                             sps_pkg::SPS_TX_START, sps_pkg::SPS_TX_DATA},
                                             q.rb8, q.ri, q.ti};
            default:        next_q.pslverr = 1'b1;
         endcase
      end
      if (wr && paddr == `SPS_CTRL_ADDR)
      begin
         next_q.mode = pwdata[`SPS_CTRL_MODE_LO +: 2];
         next_q.ren  = pwdata[`SPS_CTRL_REN];
         next_q.sm2  = pwdata[`SPS_CTRL_SM2];
         next_q.tb8  = pwdata[`SPS_CTRL_TB8];
         next_q.baud_double_bit = pwdata[`SPS_CTRL_BAUD_DOUBLE_BIT];
      end
      // Write one to clear; a set in the same cycle wins below
      if (wr && paddr == `SPS_STAT_ADDR)
      begin
         next_q.ti = q.ti & ~pwdata[`SPS_STAT_TI];
         next_q.ri = q.ri & ~pwdata[`SPS_STAT_RI];
      end
      wr_data = wr && (paddr == `SPS_DATA_ADDR) && (q.tx_state == sps_pkg::SPS_TX_IDLE);

      // Transmit sequencer
      // Stop marker not yet shifted in: a zero ninth bit must not end the frame early
      tx_last = (q.tx_sr[8:2] == 7'h00) && q.tx_sr[1] && !q.tx_fill;
      unique case (q.tx_state)
         sps_pkg::SPS_TX_IDLE:
         begin
            if (wr_data)
            begin
               next_q.tx_sr    = {q.mode[1] ? q.tb8 : 1'b1, pwdata[7:0]};
               next_q.tx_fill  = q.mode[1];
               next_q.tx_state = sps_pkg::SPS_TX_PEND;
            end
         end
         sps_pkg::SPS_TX_PEND:
         begin
            if (q.mode == `SPS_MODE0 && mc_end)
            begin
               next_q.tx_state = sps_pkg::SPS_TX_M0;
            end
            else if (q.mode != `SPS_MODE0 && tx_roll)
            begin
               next_q.tx_state = sps_pkg::SPS_TX_START;
            end
         end
         sps_pkg::SPS_TX_M0:
         begin
            if (mc_end)
            begin
               next_q.tx_sr = {1'b0, q.tx_sr[8:1]};
               if (tx_last)
               begin
                  next_q.tx_state = sps_pkg::SPS_TX_IDLE;
                  set_ti          = 1'b1;
               end
            end
         end
         sps_pkg::SPS_TX_START:
         begin
            if (tx_roll)
            begin
               next_q.tx_state = sps_pkg::SPS_TX_DATA;
            end
         end
         sps_pkg::SPS_TX_DATA:
         begin
            if (tx_roll)
            begin
               next_q.tx_sr   = {q.tx_fill, q.tx_sr[8:1]};
               next_q.tx_fill = 1'b0;
               if (tx_last)
               begin
                  next_q.tx_state = sps_pkg::SPS_TX_IDLE;
                  set_ti          = 1'b1;
               end
            end
         end
         default: next_q.tx_state = sps_pkg::SPS_TX_IDLE;
      endcase

      // Receive sequencer
      vote = sps_major(q.s7, q.s8, q.sync2);
      unique case (q.rx_state)
         sps_pkg::SPS_RX_IDLE:
         begin
            if (q.mode == `SPS_MODE0)
            begin
               if (q.ren && !q.ri && q.tx_state == sps_pkg::SPS_TX_IDLE)
               begin
                  next_q.rx_state = sps_pkg::SPS_RX_M0_ARM;
               end
            end
            else if (q.ren && tick && q.rx_prev && !q.sync2)
            begin
               next_q.rx_div   = 4'h0;
               next_q.rx_sr    = `SPS_RX_PRESET;
               next_q.rx_state = sps_pkg::SPS_RX_BITS;
            end
         end
         sps_pkg::SPS_RX_M0_ARM:
         begin
            if (mc_end)
            begin
               next_q.rx_sr    = {1'b1, `SPS_M0_RX_PRESET};
               next_q.rx_state = sps_pkg::SPS_RX_M0_RECV;
            end
         end
         sps_pkg::SPS_RX_M0_RECV:
         begin
            if (q.phase == `SPS_M0_SAMPLE)
            begin
               next_q.s7 = q.sync2;
            end
            if (mc_end)
            begin
               next_q.rx_sr[7:0] = {q.rx_sr[6:0], q.s7};
               if (!q.rx_sr[7])
               begin
                  next_q.serial_buffer     = {<<{q.rx_sr[6:0], q.s7}}; // first bit is LSB
                  next_q.rx_state = sps_pkg::SPS_RX_IDLE;
                  set_ri          = 1'b1;
               end
            end
         end
         sps_pkg::SPS_RX_BITS:
         begin
            if (tick)
            begin
               next_q.rx_div = q.rx_div + 4'h1;
               if (q.rx_div == `SPS_SAMPLE_A)
               begin
                  next_q.s7 = q.sync2;
               end
               if (q.rx_div == `SPS_SAMPLE_B)
               begin
                  next_q.s8 = q.sync2;
               end
               if (q.rx_div == `SPS_SAMPLE_C)
               begin
                  next_q.rx_sr = {vote, q.rx_sr[8:1]};
                  if (q.rx_sr == `SPS_RX_PRESET && vote)
                  begin
                     next_q.rx_state = sps_pkg::SPS_RX_IDLE;
                  end
                  else if (q.rx_sr != `SPS_RX_PRESET && !q.rx_sr[0])
                  begin
                     if (!q.ri && (!q.sm2 || vote))
                     begin
                        next_q.serial_buffer = q.rx_sr[8:1];
                        next_q.rb8  = vote;
                        set_ri      = 1'b1;
                     end
                     next_q.rx_state = (q.mode == `SPS_MODE1) ? sps_pkg::SPS_RX_IDLE
                                                              : sps_pkg::SPS_RX_GAP;
                  end
               end
            end
         end
         sps_pkg::SPS_RX_GAP:
         begin
            if (tick)
            begin
               next_q.rx_div = q.rx_div + 4'h1;
               if (q.rx_div == `SPS_SAMPLE_C)
               begin
                  next_q.rx_state = sps_pkg::SPS_RX_IDLE;
               end
            end
         end
         default: next_q.rx_state = sps_pkg::SPS_RX_IDLE;
      endcase

      // Flags: hardware set wins over a software clear
      next_q.ti = next_q.ti | set_ti;
      next_q.ri = next_q.ri | set_ri;

      // Pins follow the next state so they line up with it
      m0_clk          = (next_q.phase >= `SPS_M0_CLK_HIGH);
      next_q.rxd_oe_n = (next_q.tx_state != sps_pkg::SPS_TX_M0);
      next_q.rxd_out  = (next_q.tx_state == sps_pkg::SPS_TX_M0) ? next_q.tx_sr[0] : 1'b1;
      if (next_q.tx_state == sps_pkg::SPS_TX_M0 || next_q.rx_state == sps_pkg::SPS_RX_M0_RECV)
      begin
         next_q.txd = m0_clk;
      end
      else if (next_q.tx_state == sps_pkg::SPS_TX_START)
      begin
         next_q.txd = 1'b0;
      end
      else if (next_q.tx_state == sps_pkg::SPS_TX_DATA)
      begin
         next_q.txd = next_q.tx_sr[0];
      end
      else
      begin
         next_q.txd = 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q          <= '0;
         q.txd      <= 1'b1;
         q.rxd_out  <= 1'b1;
         q.rxd_oe_n <= 1'b1;
         q.sync1    <= 1'b1;
         q.sync2    <= 1'b1;
         q.rx_prev  <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Outputs straight from the state register
   assign prdata   = q.prdata;
   assign pready   = q.pready;
   assign pslverr  = q.pslverr;
   assign rxd_out  = q.rxd_out;
   assign rxd_oe_n = q.rxd_oe_n;
   assign txd      = q.txd;

   // *****************************************************
   // Assertions
   // *****************************************************

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_m0_tx_load: assert property (
      wr_data && q.mode == `SPS_MODE0 |=> q.tx_sr[8] && q.tx_state == sps_pkg::SPS_TX_PEND
         ##[1:12] q.tx_state == sps_pkg::SPS_TX_M0)
      else $error("mode 0 load or start late");

   a_m0_pin_drive: assert property (
      q.tx_state == sps_pkg::SPS_TX_M0 |-> !q.rxd_oe_n && q.rxd_out == q.tx_sr[0])
      else $error("mode 0 data not driven");

   a_m0_tx_end: assert property (
      q.tx_state == sps_pkg::SPS_TX_M0 && mc_end && tx_last
         |=> q.ti && q.phase == 4'h0 && q.tx_state == sps_pkg::SPS_TX_IDLE)
      else $error("mode 0 send did not end at phase one");

   a_m0_rx_preset: assert property (
      q.rx_state == sps_pkg::SPS_RX_M0_ARM && mc_end
         |=> q.rx_sr[7:0] == `SPS_M0_RX_PRESET && q.rx_state == sps_pkg::SPS_RX_M0_RECV)
      else $error("mode 0 receive preset wrong");

   a_m0_shift_clock: assert property (
      q.rx_state == sps_pkg::SPS_RX_M0_RECV && q.phase == 4'h2 |-> !q.txd ##6 q.txd)
      else $error("mode 0 shift clock shape wrong");

   a_m0_rx_done: assert property (
      q.rx_state == sps_pkg::SPS_RX_M0_RECV && mc_end && !q.rx_sr[7]
         |=> q.ri && q.rx_state == sps_pkg::SPS_RX_IDLE && q.serial_buffer[7] == $past(q.s7))
      else $error("mode 0 receive did not complete");

   a_tx_start_low: assert property (
      q.tx_state == sps_pkg::SPS_TX_START |-> !q.txd)
      else $error("start bit not low");

   a_async_tx_end: assert property (
      q.tx_state == sps_pkg::SPS_TX_DATA && tx_roll && tx_last
         |=> q.ti && q.tx_state == sps_pkg::SPS_TX_IDLE && q.txd)
      else $error("frame end not flagged");

   a_false_start: assert property (
      q.rx_state == sps_pkg::SPS_RX_BITS && tick && q.rx_div == `SPS_SAMPLE_C
         && q.rx_sr == `SPS_RX_PRESET && vote |=> q.rx_state == sps_pkg::SPS_RX_IDLE)
      else $error("false start not rejected");

   a_rx_blocked: assert property (
      q.rx_state == sps_pkg::SPS_RX_BITS && q.ri && !set_ri |=> $stable(q.serial_buffer))
      else $error("buffer changed while flag set");

endmodule : sps_engine

/* sps_defines.svh */
// Register map, field positions, shift register presets and timing counts of the serial engine
// What this block does
// - Mode 0 write loads byte plus ninth marker
// - Mode 0 send drives data and shift clock
// - Zero fill, last shift, flag at S1
// - Mode 0 receive presets 11111110 then activates
// - Mode 0 receive shifts pin sample in left
// - Zero at left: last shift, load, flag
// - Mode 1 send waits for divider rollover
// - Start bit, then data gate, then shifting
// - Mode 1 ends at tenth rollover
// - Falling edge resets divider, loads all ones
// - Majority vote of samples seven, eight, nine
// - High start vote aborts the frame
// - Mode 1 accepts on clear flag, filter
// - Start bit rightmost: final shift, evaluate frame
// - Mode 2 rate is oscillator over 32/64
// - Modes 2/3 load ninth bit, stop fill
// - Modes 2/3 end at eleventh rollover
// - Modes 2/3 accept on flag and ninth
// - Receiver rearms at or after final shift
// - Mode 0 shifts once per twelve clocks
// - Timer source rate over 32, doubled option
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Register byte addresses
`define SPS_CTRL_ADDR    8'h00
`define SPS_DATA_ADDR    8'h04
`define SPS_STAT_ADDR    8'h08

// Control field positions
`define SPS_CTRL_MODE_LO 0
`define SPS_CTRL_REN     2
`define SPS_CTRL_SM2     3
`define SPS_CTRL_TB8     4
`define SPS_CTRL_BAUD_DOUBLE_BIT    5

// Status field positions
`define SPS_STAT_TI      0
`define SPS_STAT_RI      1

// Mode encodings
`define SPS_MODE0        2'h0
`define SPS_MODE1        2'h1
`define SPS_MODE2        2'h2

// Machine cycle of twelve oscillator clocks
`define SPS_MC_LAST      4'hB
`define SPS_M0_CLK_HIGH  4'h6
`define SPS_M0_SAMPLE    4'hA

// Mode 2 prescale: four clocks per tick (1/64) or two (1/32)
`define SPS_M2_SLOW      2'h3
`define SPS_M2_FAST      2'h1

// Bit divider states
`define SPS_ROLL         4'hF
`define SPS_SAMPLE_A     4'h7
`define SPS_SAMPLE_B     4'h8
`define SPS_SAMPLE_C     4'h9

// Shift register presets
`define SPS_M0_RX_PRESET 8'hFE
`define SPS_RX_PRESET    9'h1FF

`endif

/* sps_pkg.sv */
// Types of the serial engine: state machines and the state record
package sps_pkg;

   // Transmit sequencer
   typedef enum logic [2:0] {
      SPS_TX_IDLE,
      SPS_TX_PEND,
      SPS_TX_M0,
      SPS_TX_START,
      SPS_TX_DATA
   } sps_tx_state_t;

   // Receive sequencer
   typedef enum logic [2:0] {
      SPS_RX_IDLE,
      SPS_RX_M0_ARM,
      SPS_RX_M0_RECV,
      SPS_RX_BITS,
      SPS_RX_GAP
   } sps_rx_state_t;

   // Whole state of the engine
   typedef struct packed {
      logic [1:0]    mode;
      logic          ren;
      logic          sm2;
      logic          tb8;
      logic          baud_double_bit;
      logic [7:0]    serial_buffer;
      logic          ti;
      logic          ri;
      logic          rb8;
      sps_tx_state_t tx_state;
      logic [8:0]    tx_sr;
      logic          tx_fill;
      logic [3:0]    tx_div;
      sps_rx_state_t rx_state;
      logic [8:0]    rx_sr;
      logic [3:0]    rx_div;
      logic          s7;
      logic          s8;
      logic          rx_prev;
      logic [3:0]    phase;
      logic [1:0]    pre_div;
      logic          half;
      logic          sync1;
      logic          sync2;
      logic          txd;
      logic          rxd_out;
      logic          rxd_oe_n;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } sps_state_t;

endpackage : sps_pkg

/* sps_peer.sv */
// Serial peer model: shift-register partner and asynchronous terminal
`timescale 1ns/1ps

module sps_peer (
   // Clock
   input  wire logic        pclk,
   // Engine pins
   input  wire logic        txd,
   input  wire logic        rxd_out,
   input  wire logic        rxd_oe_n,
   // Capture set-up: frame bits (0 = shift mode) and bit time in clocks
   input  wire logic [3:0]  cap_bits,
   input  wire logic [7:0]  bit_cycles,
   // Line drive and results
   output logic             rxd_drv,
   output logic             done,
   output logic [31:0]      result
);
   logic        prev;
   logic [10:0] sr;
   logic [7:0]  per;
   logic [7:0]  feed;
   int          cnt;
   int          idx;

   // Line pulled up while released
   initial
   begin
      rxd_drv = 1'b1;
      done = 1'b0;
      result = 32'h0;
      prev = 1'b1;
      per = 8'h00;
      sr = 11'h000;
      cnt = 0;
      idx = 9;
   end

   // Arm a byte for the shift clock, LSB first
   task automatic feed_m0(input logic [7:0] b);
      feed = b;
      idx = 0;
   endtask : feed_m0

   // Send one frame, LSB first, then release the line
   task automatic send(input logic [10:0] f, input int n, input int bc);
      for (int k = 0; k < n; k++)
      begin
         rxd_drv <= f[k];
         repeat (bc) @(posedge pclk);
      end
      rxd_drv <= 1'b1;
   endtask : send

   // Watch the transmit pin every clock
   initial
   begin
      forever
      begin
         @(posedge pclk);
         done <= 1'b0;
         per <= per + 8'h01;
         if (cap_bits != 4'h0 && prev && !txd)
         begin
            sr = 11'h000;
            repeat (bit_cycles / 2) @(posedge pclk);
            for (int k = 0; k < cap_bits; k++)
            begin
               sr[k] = txd;
               repeat (bit_cycles) @(posedge pclk);
            end
            done <= 1'b1;
            result <= {21'h0, sr};
         end
         else if (cap_bits == 4'h0)
         begin
            if (!prev && txd)
            begin
               per <= 8'h01;
               if (!rxd_oe_n)
               begin
                  sr[7:0] = {rxd_out, sr[7:1]};
                  cnt++;
                  if (cnt == 8)
                  begin
                     done <= 1'b1;
                     result <= {16'h0, per, sr[7:0]};
                     cnt = 0;
                  end
               end
            end
            if (idx == 8 && per == 8'h06)
            begin
               rxd_drv <= 1'b1;     // Hold time over: release
               idx = 9;
            end
            else if (prev && !txd && idx < 8)
            begin
               rxd_drv <= feed[idx];
               idx++;
            end
         end
         prev = txd;
      end
   end
endmodule : sps_peer

/* tb_top.sv */
// Self-checking bench of the serial engine against its peer model
`timescale 1ns/1ps
`include "sps_defines.svh"

module tb_top;
   typedef struct {string nm; logic [32:0] v;} sps_exp_t;

   logic        pclk, presetn, psel, penable, pwrite, timer_overflow, poll, t;
   logic        pready, pslverr, rxd_in, rxd_out, rxd_oe_n, txd, rxd_drv, done;
   logic [7:0]  paddr, ov_cnt, b, bit_cycles;
   logic [3:0]  cap_bits;
   logic [31:0] pwdata, prdata, rd_val, result;
   sps_exp_t    exp_q[$];
   int          err_count, checked, seed;
   logic [7:0]  ctl[4] = '{8'h21, 8'h02, 8'h22, 8'h03};
   logic [7:0]  bcs[4] = '{8'd48, 8'd64, 8'd32, 8'd96};

   // Receive pin level from both drivers
   assign rxd_in = rxd_oe_n ? rxd_drv : rxd_out;

   sps_engine uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_overflow(timer_overflow), .rxd_in(rxd_in),
      .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd));

   sps_peer peer (.pclk(pclk), .txd(txd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
      .cap_bits(cap_bits), .bit_cycles(bit_cycles), .rxd_drv(rxd_drv), .done(done),
      .result(result));

   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Timer overflow pulse every third clock
   always @(posedge pclk)
   begin
      if (!presetn)
      begin
         ov_cnt <= 8'h00;
         timer_overflow <= 1'b0;
      end
      else
      begin
         ov_cnt <= (ov_cnt == 8'h02) ? 8'h00 : ov_cnt + 8'h01;
         timer_overflow <= (ov_cnt == 8'h02);
      end
   end

   task automatic test_done;
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic timeout_hit;
      err_count++;
      test_done();
   endtask : timeout_hit

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] ex);
      checked++;
      if (seen !== ex)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check

   task automatic note_exp(input string nm, input logic [32:0] v);
      exp_q.push_back('{nm, v});
   endtask : note_exp

   // Result watcher: oldest note against each read answer outside flag polling, or peer frame
   always @(posedge pclk)
   begin
      if ((psel && penable && pready === 1'b1 && !pwrite && !poll) || done === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("queue", 33'h0, 33'h1);
         else
         begin
            check(exp_q[0].nm, done ? {1'b0, result} : {pslverr, prdata}, exp_q[0].v);
            exp_q.delete(0);
         end
      end
   end

   // One APB transfer, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd_val = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20) timeout_hit();
   endtask : apb

   task automatic rd(input logic [7:0] a, input string nm, input logic [32:0] v);
      note_exp(nm, v);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wait_flag(input int k);
      int n;
      poll = 1'b1;
      rd_val = 32'h0;
      for (n = 0; n < 4000 && rd_val[k] !== 1'b1; n++)
         apb(1'b0, `SPS_STAT_ADDR, 32'h0);
      poll = 1'b0;
      if (n >= 4000) timeout_hit();
   endtask : wait_flag

   task automatic wait_peer;
      int n;
      for (n = 0; n < 3000 && done !== 1'b1; n++)
         @(posedge pclk);
      if (n >= 3000) timeout_hit();
   endtask : wait_peer

   // One received frame, then status and buffer read back
   task automatic rx_case(input logic [7:0] c, input int n, input int bc,
      input logic [10:0] f, input logic [7:0] st, input logic [7:0] dat, input logic clr);
      apb(1'b1, `SPS_CTRL_ADDR, {24'h0, c});
      peer.send(f, n, bc);
      repeat (2 * bc) @(posedge pclk);
      rd(`SPS_STAT_ADDR, "rx_stat", {25'h0, st});
      rd(`SPS_DATA_ADDR, "rx_data", {25'h0, dat});
      if (clr) apb(1'b1, `SPS_STAT_ADDR, 32'h3);
   endtask : rx_case

   // ****************
   // Main sequence
   // ****************
   initial
   begin
      seed = 79316;
      {presetn, psel, penable, pwrite, poll} = 5'h00;
      {paddr, pwdata, cap_bits, bit_cycles} = 52'h0;
      err_count = 0;
      checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`SPS_CTRL_ADDR, "ctrl_rst", 33'h0);
      rd(`SPS_STAT_ADDR, "stat_rst", 33'h0);
      rd(8'h0C, "unmapped", 33'h1_0000_0000);
      b = $random(seed);
      note_exp("m0_tx", {17'h0, 8'h0C, b});
      apb(1'b1, `SPS_DATA_ADDR, {24'h0, b});
      wait_peer();
      wait_flag(0);
      rd(`SPS_STAT_ADDR, "m0_ti", 33'h1);
      apb(1'b1, `SPS_STAT_ADDR, 32'h1);
      b = $random(seed);
      peer.feed_m0(b);
      apb(1'b1, `SPS_CTRL_ADDR, 32'h4);
      wait_flag(1);
      apb(1'b1, `SPS_CTRL_ADDR, 32'h0);
      rd(`SPS_DATA_ADDR, "m0_rx", {25'h0, b});
      rd(`SPS_STAT_ADDR, "m0_ri", 33'h2);
      apb(1'b1, `SPS_STAT_ADDR, 32'h3);
      for (int k = 0; k < 4; k++)
      begin
         b = $random(seed);
         t = $random(seed);
         cap_bits <= (k == 0) ? 4'hA : 4'hB;
         bit_cycles <= bcs[k];
         apb(1'b1, `SPS_CTRL_ADDR, {24'h0, ctl[k] | {3'h0, t, 4'h0}});
         note_exp("async_tx", (k == 0) ? {23'h0, 1'b1, b, 1'b0}
            : {22'h0, 1'b1, t, b, 1'b0});
         apb(1'b1, `SPS_DATA_ADDR, {24'h0, b});
         wait_peer();
         wait_flag(0);
         rd(`SPS_STAT_ADDR, "tx_ti", 33'h1);
         apb(1'b1, `SPS_STAT_ADDR, 32'h1);
      end
      cap_bits <= 4'h0;
      b = $random(seed);
      rx_case(8'h25, 10, 48, {1'b1, b, 1'b0}, 8'h06, b, 1'b0);
      rx_case(8'h25, 10, 48, {1'b1, ~b, 1'b0}, 8'h06, b, 1'b1);
      rx_case(8'h2D, 10, 48, {1'b0, ~b, 1'b0}, 8'h04, b, 1'b1);
      peer.send(11'h000, 1, 12);
      repeat (48) @(posedge pclk);
      b = $random(seed);
      rx_case(8'h25, 10, 48, {1'b1, b, 1'b0}, 8'h06, b, 1'b1);
      rx_case(8'h0E, 11, 64, {2'h2, ~b, 1'b0}, 8'h04, b, 1'b1);
      b = $random(seed);
      rx_case(8'h0E, 11, 64, {2'h3, b, 1'b0}, 8'h06, b, 1'b1);
      b = $random(seed);
      rx_case(8'h07, 11, 96, {2'h2, b, 1'b0}, 8'h02, b, 1'b1);
      test_done();
   end
endmodule : tb_top
